// ---- time_pwm_codec.sv ----
// Behaviour
// R1 - Writing seconds MSB word loads staged time
// R2 - Reading word below time register snapshots accumulator
// R3 - Access to programmed address pushes time FIFO
// R4 - Armed sync edge pushes time, once/continuous
// R5 - Frame mode: time captured at second, sent
// R6 - Armed sync edge loads staged time, once/continuous
// R7 - Armed decoder loads time from received frame
// R8 - Pin interrupt edge captures accumulator time
// R9 - Countdown timer in 2.5ns steps loads/captures
// R10 - Trigger pin captures into selected register
// R11 - Trigger pin output asserts at match time
// R12 - Carrier rising edges never move
// R13 - Space 50%, zero 25%, one 75% high
// R14 - Carrier period programmable, slow for signature; signature symbols use the same period_q as frames
// R15 - Eight programmed symbols, first forced non-space
// R16 - Signature mode sends no frames
// R17 - Signature starts on accumulator or alternate pulse
// R18 - Frame: 23 header, 88 payload, parity
// R19 - Parity covers whole frame, both directions
// R20 - Header: command, source, broadcast, destination
// R21 - Four native command codes recognised
// R22 - Broadcast frames accepted regardless of destination
// R23 - Time is 48s, 32ns, 8 sub-ns
// R24 - Even parity over all frame bits
// R25 - Drop misaddressed or bad-parity frames
`include "time_codec_map.svh"

module time_pwm_codec import time_codec_pkg::*; #(
    parameter int FIFO_DEPTH = 4,
    parameter int PER_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic hwrite,
    input wire logic [1:0] htrans,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ext_sync_in,
    input wire logic gpio_in,
    input wire logic pps_alt_in,
    input wire logic carrier_in,
    output logic carrier_out,
    output logic gpio_trig_out,
    output logic second_pulse_out
);
    localparam int PW = $clog2(FIFO_DEPTH);
    localparam logic [31:0] TOD_STEP_NS = `CLK_PERIOD_PS / `PS_PER_NS;
    localparam logic [31:0] TIMER_STEP = `CLK_PERIOD_PS / `SYS_TICK_PS;

    function automatic logic [31:0] time_word(time_t t, logic [1:0] i);
        case (i)
            2'h0: time_word = {24'h00_0000, t[7:0]};
            2'h1: time_word = t[39:8];
            2'h2: time_word = t[71:40];
            default: time_word = {16'h0000, t[87:72]};
        endcase
    endfunction

    // Bus address/data phase
    logic dph_wr_q, dph_rd_q;
    logic [7:0] dph_addr_q;
    logic [15:0] ctrl_q, ctrl_d;
    logic [23:0] ids_q;
    logic [15:0] sig_q;
    logic [PER_W-1:0] period_q;
    logic [31:0] timer_q;
    logic [7:0] trig_addr_q;
    time_t stage_q, acc_q, snap_q;
    logic [79:0] match_q;
    logic [FIFO_DEPTH-1:0][92:0] fifo_mem;
    logic [PW-1:0] wr_ptr_q, rd_ptr_q;
    logic [PW:0] fifo_cnt_q;
    logic fifo_ovf_q;
    logic s1_q, s2_q, s3_q, g1_q, g2_q, g3_q, p1_q, p2_q, p3_q;
    tx_state_t tx_q;
    logic [111:0] tx_sh_q;
    logic [6:0] tx_cnt_q;
    logic [111:0] rx_sh_q;
    logic [6:0] rx_cnt_q;
    logic [2:0] rx_cmd_q;
    logic [7:0] rx_ok_q, rx_drop_q;
    logic enc_take, dec_valid;
    sym_t dec_sym;

    wire addr_ok = hsel & htrans[1] & hready;
    wire map_hi = (haddr[31:8] == 24'h00_0000);
    wire rd_fire = dph_rd_q;
    wire wr_fire = dph_wr_q;
    wire [7:0] a = dph_addr_q;
    wire [1:0] wi = a[3:2];
    wire wr_ctrl = wr_fire & (a == `OFF_CTRL);
    wire wr_stage = wr_fire & (a[7:4] == 4'(`OFF_STAGE >> 4));
    wire wr_match = wr_fire & (a >= `OFF_MATCH) & (a < `OFF_RX_STAT);
    wire host_load = wr_fire & (a == `OFF_STAGE_MSB); // R1
    wire snap_rd = rd_fire & (a == `OFF_SNAP_ARM); // R2
    wire csr_trig = ctrl_q[`CB_CSR_TRIG] & (rd_fire | wr_fire) &
        (a == trig_addr_q); // R3
    wire fifo_pop = rd_fire & (a == `OFF_FIFO_MSB) & (fifo_cnt_q != '0);

    // Synchronised pin edges
    wire ext_edge = s2_q & ~s3_q;
    wire gpio_edge = g2_q & ~g3_q;
    wire alt_edge = p2_q & ~p3_q;

    wire ext_cap = ext_edge & ctrl_q[`CB_CAP_EXT]; // R4
    wire ext_load = ext_edge & ctrl_q[`CB_LOAD_EXT]; // R6
    wire irq_cap = gpio_edge & ctrl_q[`CB_GPIO_IRQ]; // R8
    wire gpio_cap = gpio_edge & ctrl_q[`CB_GPIO_TRIG_IN]; // R10
    wire gpio_snap = gpio_cap & ~ctrl_q[`CB_TRIG_IN_FIFO]; // R10
    wire gpio_fifo = gpio_cap & ctrl_q[`CB_TRIG_IN_FIFO]; // R10
    wire timer_exp = (timer_q != 32'h0000_0000) &
        (timer_q <= TIMER_STEP); // R9
    wire timer_load = timer_exp & ctrl_q[`CB_TIMER_LOAD]; // R9
    wire timer_cap = timer_exp & ~ctrl_q[`CB_TIMER_LOAD]; // R9

    // Received frame checks
    wire rx_done = dec_valid & (dec_sym != SYM_SPACE) &
        (rx_cnt_q == `FRAME_LEN - 7'h01);
    wire [111:0] rx_frame = {rx_sh_q[110:0], dec_sym == SYM_ONE};
    wire rx_par_ok = ~^rx_frame; // R19 R24
    wire [2:0] rx_cmd = rx_frame[111:109];
    wire rx_bcast = rx_frame[100];
    wire [7:0] rx_dest = rx_frame[99:92];
    wire rx_known = (rx_cmd == `CMD_SECOND) | (rx_cmd == `CMD_SYNC) |
        (rx_cmd == `CMD_RREAD) | (rx_cmd == `CMD_RWRITE); // R21
    wire rx_for_me = rx_bcast | (rx_dest == ids_q[23:16]); // R22 R25
    wire rx_accept = rx_done & rx_par_ok & rx_for_me & rx_known; // R25
    wire rx_load = rx_accept & (rx_cmd == `CMD_SECOND) &
        ctrl_q[`CB_LOAD_PWM]; // R7

    // Accumulator arithmetic
    wire [31:0] ns_sum = acc_q[39:8] + TOD_STEP_NS;
    wire ns_wrap = (ns_sum >= `NS_PER_SEC);
    wire any_load = host_load | ext_load | timer_load | rx_load;
    wire time_t load_val = rx_load ? time_t'(rx_frame[88:1]) : stage_q;
    wire time_t acc_run = {acc_q[87:40] + 48'(ns_wrap),
        ns_wrap ? ns_sum - `NS_PER_SEC : ns_sum, acc_q[7:0]}; // R23

    wire [4:0] push_tag;
    assign push_tag[`TAG_CSR] = csr_trig;
    assign push_tag[`TAG_EXT] = ext_cap;
    assign push_tag[`TAG_IRQ] = irq_cap;
    assign push_tag[`TAG_TIMER] = timer_cap;
    assign push_tag[`TAG_GPIO] = gpio_fifo;
    wire fifo_full = (fifo_cnt_q == (PW+1)'(FIFO_DEPTH));
    wire push = (push_tag != 5'h00);
    wire push_ok = push & (~fifo_full | fifo_pop);

    // Encoder sequencing
    wire pps_src = ctrl_q[`CB_PPS_ALT] ? alt_edge : second_pulse_out; // R17
    wire tx_start = ctrl_q[`CB_ENC_EN] & pps_src & (tx_q == TX_IDLE);
    wire [1:0] sig_first = (sig_q[15:14] == SYM_SPACE) ? SYM_ZERO :
        sig_q[15:14]; // R15
    wire [22:0] tx_hdr = {`CMD_SECOND, ids_q[7:0], ctrl_q[`CB_BCAST],
        ids_q[15:8], 3'h0}; // R20
    wire [110:0] tx_body = {tx_hdr, acc_q}; // R5 R18
    wire sym_t enc_sym = (tx_q == TX_SIG) ? sym_t'(tx_sh_q[111:110]) :
        (tx_q == TX_FRAME) ? (tx_sh_q[111] ? SYM_ONE : SYM_ZERO) :
        SYM_SPACE;

    wire [31:0] fifo_word = time_word(fifo_mem[rd_ptr_q][87:0], 2'(wi - 2'h2));
    wire [31:0] rd_mux =
        (a == `OFF_CTRL) ? {16'h0000, ctrl_q} :
        (a == `OFF_IDS) ? {8'h00, ids_q} :
        (a == `OFF_SIG) ? {16'h0000, sig_q} :
        (a == `OFF_PERIOD) ? 32'(period_q) :
        (a == `OFF_TIMER) ? timer_q :
        (a == `OFF_TRIG) ? {24'h00_0000, trig_addr_q} :
        (a[7:4] == 4'(`OFF_STAGE >> 4)) ? time_word(stage_q, wi) :
        (a == `OFF_SNAP_ARM) ? 32'h0000_0000 :
        (a >= `OFF_SNAP && a < `OFF_FIFO_STAT) ?
            time_word(snap_q, 2'(wi - 2'h1)) :
        (a == `OFF_FIFO_STAT) ? {fifo_ovf_q, 18'h0_0000,
            fifo_mem[rd_ptr_q][92:88], 8'(fifo_cnt_q)} :
        (a >= `OFF_FIFO && a <= `OFF_FIFO_MSB) ? fifo_word :
        (a >= `OFF_MATCH && a < `OFF_RX_STAT) ?
            time_word({match_q, 8'h00}, 2'(wi - 2'h1)) :
        (a == `OFF_RX_STAT) ? {5'h00, rx_cmd_q, 8'h00, rx_drop_q, rx_ok_q} :
        32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_q <= 1'b0;
            dph_rd_q <= 1'b0;
            dph_addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            dph_wr_q <= addr_ok & hwrite & map_hi;
            dph_rd_q <= addr_ok & ~hwrite;
            dph_addr_q <= map_hi ? haddr[7:0] : 8'hFC;
            hreadyout <= ~(addr_ok & ~hwrite);
            hrdata <= rd_fire ? rd_mux : hrdata;
        end
    end

    // Software write wins over the one-shot arm clearing
    always_comb begin
        ctrl_d = ctrl_q;
        if (ext_cap & ~ctrl_q[`CB_CAP_EXT_CONT])
            ctrl_d[`CB_CAP_EXT] = 1'b0; // R4
        if (ext_load & ~ctrl_q[`CB_LOAD_EXT_CONT])
            ctrl_d[`CB_LOAD_EXT] = 1'b0; // R6
        if (rx_load & ~ctrl_q[`CB_LOAD_PWM_CONT])
            ctrl_d[`CB_LOAD_PWM] = 1'b0; // R7
        if (wr_ctrl)
            ctrl_d = hwdata[15:0];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `CTRL_RST;
            ids_q <= 24'h00_0000;
            sig_q <= 16'h0000;
            period_q <= PER_W'(`PERIOD_RST);
            trig_addr_q <= 8'h00;
            stage_q <= '0;
            match_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            if (wr_fire & (a == `OFF_IDS)) ids_q <= hwdata[23:0];
            if (wr_fire & (a == `OFF_SIG)) sig_q <= hwdata[15:0];
            if (wr_fire & (a == `OFF_PERIOD))
                period_q <= hwdata[PER_W-1:0]; // R14
            if (wr_fire & (a == `OFF_TRIG)) trig_addr_q <= hwdata[7:0];
            if (wr_stage) begin
                case (wi)
                    2'h0: stage_q[7:0] <= hwdata[7:0];
                    2'h1: stage_q[39:8] <= hwdata;
                    2'h2: stage_q[71:40] <= hwdata;
                    default: stage_q[87:72] <= hwdata[15:0];
                endcase
            end
            if (wr_match) begin
                case (wi)
                    2'h2: match_q[31:0] <= hwdata;
                    2'h3: match_q[63:32] <= hwdata;
                    default: match_q[79:64] <= hwdata[15:0];
                endcase
            end
        end
    end

    // The MSB word goes straight in so the load sees the full value
    wire time_t host_val = {hwdata[15:0], stage_q[71:0]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q <= '0;
            snap_q <= '0;
            second_pulse_out <= 1'b0;
            gpio_trig_out <= 1'b0;
            timer_q <= 32'h0000_0000;
        end else begin
            if (host_load) acc_q <= host_val; // R1
            else if (any_load) acc_q <= load_val; // R6 R7 R9
            else acc_q <= acc_run;
            second_pulse_out <= ns_wrap & ~any_load;
            if (snap_rd | gpio_snap) snap_q <= acc_q; // R2 R10
            gpio_trig_out <= ctrl_q[`CB_GPIO_TRIG_OUT] &
                (acc_q[87:8] >= match_q); // R11
            if (wr_fire & (a == `OFF_TIMER)) timer_q <= hwdata; // R9
            else if (timer_exp) timer_q <= 32'h0000_0000;
            else if (timer_q != 32'h0000_0000)
                timer_q <= timer_q - TIMER_STEP; // R9
        end
    end

    // Capture FIFO; a push into a full FIFO is dropped and flagged unless a pop lands in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            fifo_cnt_q <= '0;
            fifo_ovf_q <= 1'b0;
            fifo_mem <= '0;
        end else begin
            if (push_ok) begin
                fifo_mem[wr_ptr_q] <= {push_tag, acc_q}; // R3 R4 R8
                wr_ptr_q <= PW'((32'(wr_ptr_q) + 1) % FIFO_DEPTH);
            end
            if (fifo_pop)
                rd_ptr_q <= PW'((32'(rd_ptr_q) + 1) % FIFO_DEPTH);
            fifo_cnt_q <= fifo_cnt_q + (PW+1)'(push_ok) -
                (PW+1)'(fifo_pop);
            if (push & ~push_ok) fifo_ovf_q <= 1'b1;
            else if (wr_fire & (a == `OFF_FIFO_STAT)) fifo_ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            g1_q <= 1'b0;
            g2_q <= 1'b0;
            g3_q <= 1'b0;
            p1_q <= 1'b0;
            p2_q <= 1'b0;
            p3_q <= 1'b0;
        end else begin
            s1_q <= ext_sync_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            g1_q <= gpio_in;
            g2_q <= g1_q;
            g3_q <= g2_q;
            p1_q <= pps_alt_in;
            p2_q <= p1_q;
            p3_q <= p2_q;
        end
    end

    // Frame payload is the time at the pulse that starts it: second edge, or alternate pulse when CB_PPS_ALT is set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_q <= TX_IDLE;
            tx_sh_q <= '0;
            tx_cnt_q <= 7'h00;
        end else begin
            case (tx_q)
                TX_IDLE: begin
                    if (tx_start & ctrl_q[`CB_SIG_MODE]) begin
                        tx_q <= TX_SIG; // R16 R17
                        tx_sh_q <= {sig_first, sig_q[13:0], 96'h0};
                        tx_cnt_q <= 7'(`SIG_LEN);
                    end else if (tx_start) begin
                        tx_q <= TX_FRAME; // R5
                        tx_sh_q <= {tx_body, ^tx_body}; // R19 R24
                        tx_cnt_q <= `FRAME_LEN;
                    end
                end
                TX_SIG: begin
                    if (enc_take) begin
                        tx_sh_q <= {tx_sh_q[109:0], 2'h0}; // R15
                        tx_cnt_q <= tx_cnt_q - 7'h01;
                        if (tx_cnt_q == 7'h01) tx_q <= TX_IDLE;
                    end
                end
                TX_FRAME: begin
                    if (enc_take) begin
                        tx_sh_q <= {tx_sh_q[110:0], 1'b0}; // R18
                        tx_cnt_q <= tx_cnt_q - 7'h01;
                        if (tx_cnt_q == 7'h01) tx_q <= TX_IDLE;
                    end
                end
                default: tx_q <= TX_IDLE;
            endcase
        end
    end

    // A space inside a frame abandons it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_sh_q <= '0;
            rx_cnt_q <= 7'h00;
            rx_cmd_q <= 3'h0;
            rx_ok_q <= 8'h00;
            rx_drop_q <= 8'h00;
        end else if (dec_valid) begin
            if (dec_sym == SYM_SPACE) begin
                rx_cnt_q <= 7'h00;
            end else if (rx_done) begin
                rx_cnt_q <= 7'h00;
                if (rx_accept) begin
                    rx_cmd_q <= rx_cmd;
                    rx_ok_q <= rx_ok_q + 8'h01;
                end else begin
                    rx_drop_q <= rx_drop_q + 8'h01; // R25
                end
            end else begin
                rx_sh_q <= rx_frame;
                rx_cnt_q <= rx_cnt_q + 7'h01;
            end
        end
    end

    pwm_symbol_codec #(
        .PER_W(PER_W)
    ) u_codec (
        .hclk(hclk),
        .hresetn(hresetn),
        .period(period_q),
        .enc_sym(enc_sym),
        .enc_take(enc_take),
        .carrier_out(carrier_out),
        .carrier_in(carrier_in),
        .dec_valid(dec_valid),
        .dec_sym(dec_sym)
    );
endmodule // time_pwm_codec

// ---- time_codec_map.svh ----
`ifndef TIME_CODEC_MAP_SVH
`define TIME_CODEC_MAP_SVH

`define OFF_CTRL 8'h00
`define OFF_IDS 8'h04
`define OFF_SIG 8'h08
`define OFF_PERIOD 8'h0C
`define OFF_TIMER 8'h10
`define OFF_TRIG 8'h14
`define OFF_STAGE 8'h20
`define OFF_STAGE_MSB 8'h2C
`define OFF_SNAP_ARM 8'h30
`define OFF_SNAP 8'h34
`define OFF_FIFO_STAT 8'h44
`define OFF_FIFO 8'h48
`define OFF_FIFO_MSB 8'h54
`define OFF_MATCH 8'h58
`define OFF_RX_STAT 8'h64

`define CB_SIG_MODE 0
`define CB_PPS_ALT 1
`define CB_CAP_EXT 2
`define CB_CAP_EXT_CONT 3
`define CB_LOAD_EXT 4
`define CB_LOAD_EXT_CONT 5
`define CB_LOAD_PWM 6
`define CB_LOAD_PWM_CONT 7
`define CB_GPIO_IRQ 8
`define CB_GPIO_TRIG_IN 9
`define CB_GPIO_TRIG_OUT 10
`define CB_TRIG_IN_FIFO 11
`define CB_TIMER_LOAD 12
`define CB_BCAST 13
`define CB_ENC_EN 14
`define CB_CSR_TRIG 15
`define CTRL_RST 16'h0000

`define TAG_CSR 0
`define TAG_EXT 1
`define TAG_IRQ 2
`define TAG_TIMER 3
`define TAG_GPIO 4

`define CMD_SECOND 3'h0
`define CMD_SYNC 3'h3
`define CMD_RREAD 3'h2
`define CMD_RWRITE 3'h4

`define FRAME_LEN 7'h70
`define SIG_LEN 4'h8
`define PERIOD_RST 16'h0008
`define PERIOD_MIN 16'h0004
`define NS_PER_SEC 32'h3B9A_CA00
`define CLK_PERIOD_PS 32'h0000_C350
`define SYS_TICK_PS 32'h0000_09C4
`define PS_PER_NS 32'h0000_03E8

`endif

// ---- time_codec_pkg.sv ----
package time_codec_pkg;
    // Seconds 48, nanoseconds 32, sub-ns 8
    typedef logic [87:0] time_t;
    typedef enum logic [1:0] {
        SYM_SPACE = 2'h0,
        SYM_ZERO = 2'h1,
        SYM_ONE = 2'h2
    } sym_t;
    typedef enum logic [2:0] {
        TX_IDLE = 3'h1,
        TX_SIG = 3'h2,
        TX_FRAME = 3'h4
    } tx_state_t;
endpackage

// ---- pwm_symbol_codec.sv ----
`include "time_codec_map.svh"

module pwm_symbol_codec import time_codec_pkg::*; #(
    parameter int PER_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [PER_W-1:0] period,
    input wire sym_t enc_sym,
    output logic enc_take,
    output logic carrier_out,
    input wire logic carrier_in,
    output logic dec_valid,
    output sym_t dec_sym
);
    logic [PER_W-1:0] enc_cnt_q;
    sym_t cur_sym_q;
    logic c1_q, c2_q, c3_q, seen_q;
    logic [PER_W-1:0] per_cnt_q, hi_cnt_q;

    wire [PER_W-1:0] per_eff = (period < PER_W'(`PERIOD_MIN)) ?
        PER_W'(`PERIOD_MIN) : period;
    wire [PER_W-1:0] quarter = per_eff >> 2;
    wire [PER_W-1:0] half = per_eff >> 1;
    wire [PER_W-1:0] three_q = half + quarter;
    wire [PER_W-1:0] fall_at = (cur_sym_q == SYM_ZERO) ? quarter :
        (cur_sym_q == SYM_ONE) ? three_q : half; // R13
    wire wrap = (enc_cnt_q >= per_eff - PER_W'(1));
    wire [PER_W-1:0] cnt_nx = enc_cnt_q + PER_W'(1);

    // Take at the wrap edge itself: the latched symbol is consumed
    assign enc_take = wrap;

    // Rising edge fixed at count zero; only the fall point moves
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enc_cnt_q <= '0;
            cur_sym_q <= SYM_SPACE;
            carrier_out <= 1'b0;
        end else if (wrap) begin
            enc_cnt_q <= '0;
            cur_sym_q <= enc_sym;
            carrier_out <= 1'b1; // R12
        end else begin
            enc_cnt_q <= cnt_nx;
            carrier_out <= (cnt_nx < fall_at); // R13
        end
    end

    wire rise = c2_q & ~c3_q;
    wire [PER_W+2:0] hi8 = {hi_cnt_q, 3'h0};
    wire [PER_W+2:0] per3 = (PER_W+3)'({per_cnt_q, 1'b0}) +
        (PER_W+3)'(per_cnt_q);
    wire [PER_W+2:0] per5 = (PER_W+3)'({per_cnt_q, 2'h0}) +
        (PER_W+3)'(per_cnt_q);
    wire sat = &per_cnt_q;

    // Thresholds at 3/8 and 5/8 of the measured period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            c1_q <= 1'b0;
            c2_q <= 1'b0;
            c3_q <= 1'b0;
            seen_q <= 1'b0;
            per_cnt_q <= '0;
            hi_cnt_q <= '0;
            dec_valid <= 1'b0;
            dec_sym <= SYM_SPACE;
        end else begin
            c1_q <= carrier_in;
            c2_q <= c1_q;
            c3_q <= c2_q;
            dec_valid <= rise & seen_q;
            if (rise) begin
                seen_q <= 1'b1;
                per_cnt_q <= PER_W'(1);
                hi_cnt_q <= PER_W'(1);
                dec_sym <= (hi8 < per3) ? SYM_ZERO :
                    (hi8 > per5) ? SYM_ONE : SYM_SPACE; // R13
            end else if (!sat) begin
                per_cnt_q <= per_cnt_q + PER_W'(1);
                hi_cnt_q <= hi_cnt_q + PER_W'(c2_q);
            end
        end
    end
endmodule // pwm_symbol_codec

// ---- time_pwm_codec_chk.sv ----
module time_pwm_codec_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic hwrite,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic carrier_out
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    wire logic rd_take = hsel & htrans[1] & hready & !hwrite;
    wire logic wr_take = hsel & htrans[1] & hready & hwrite;
    wire logic far = haddr[31:8] != 24'h0;
    resp_okay_a: assert property (!hresp)
        else $error("response not OKAY");
    write_nowait_a: assert property (wr_take |=> hreadyout)
        else $error("write stalled");
    read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    stall_once_a: assert property (!hreadyout |=> hreadyout)
        else $error("stall too long");
    bus_idle_a: assert property (!rd_take |=> hreadyout)
        else $error("stall without a read");
    // Read data may only move on the edge that completes a read
    data_hold_a: assert property ($changed(hrdata) |-> $past(rd_take, 2))
        else $error("read data moved");
    unmapped_zero_a: assert property (rd_take && far |=> ##1 hrdata == 0)
        else $error("unmapped read not zero");
    carrier_gap_a: assert property ($rose(carrier_out) |=>
        (!$rose(carrier_out))[*3])
        else $error("carrier rises too close");
    cover property (rd_take && far);
    cover property (wr_take);
    cover property ($rose(carrier_out));
endmodule // time_pwm_codec_chk

bind time_pwm_codec time_pwm_codec_chk chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .hwrite(hwrite), .htrans(htrans),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .carrier_out(carrier_out));

// ---- remote_timing_dev.sv ----
module remote_timing_dev (
    input wire logic carrier_out,
    output logic carrier_in,
    output logic [111:0] rx_bits,
    output int rx_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [111:0] tx_f;
    int tx_n;
    time t_up;
    time hi;
    // Carrier runs free; idle periods carry spaces
    initial begin
        tx_n = 0;
        rx_cnt = 0;
        carrier_in = 1'b0;
        #17;
        forever begin
            hi = tx_n == 0 ? 200 : tx_f[tx_n - 1] ? 300 : 100;
            carrier_in = 1'b1;
            #(hi);
            carrier_in = 1'b0;
            #(400 - hi);
            tx_n = tx_n > 0 ? tx_n - 1 : 0;
        end
    end
    always @(posedge carrier_out) t_up = $time;
    // Spaces are dropped, so the bench sees only frame bits
    always @(negedge carrier_out) begin
        if ($time - t_up != 200) begin
            rx_bits = {rx_bits[110:0], $time - t_up > 200};
            rx_cnt++;
        end
    end
    task automatic send(input logic [111:0] f);
        @(posedge carrier_in);
        tx_f = f;
        // One extra count: the period already started is a space
        tx_n = 113;
        wait (tx_n == 0);
        #800;
    endtask
endmodule // remote_timing_dev

// ---- test_time_pwm_codec.sv ----
`include "time_codec_map.svh"

module test_time_pwm_codec;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite, rdy, hresp, c_in, c_out, trig;
    logic [1:0] htrans;
    logic [2:0] pins;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [15:0] cfg [4] = '{16'h8000, 16'h0004, 16'h0100, 16'h0000};
    logic [111:0] rx;
    int rx_cnt, n0, fails, check_count;

    time_pwm_codec dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .hwrite(hwrite), .htrans(htrans), .hsize(3'h2),
        .hwdata(hwdata), .hready(rdy), .hrdata(hrdata), .hreadyout(rdy),
        .hresp(hresp), .ext_sync_in(pins[0]), .gpio_in(pins[1]),
        .pps_alt_in(pins[2]), .carrier_in(c_in), .carrier_out(c_out),
        .gpio_trig_out(trig), .second_pulse_out());
    remote_timing_dev rem (.carrier_out(c_out), .carrier_in(c_in),
        .rx_bits(rx), .rx_cnt(rx_cnt));

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    function automatic logic [111:0] mk(input logic [2:0] c, input logic b,
            input logic [7:0] dst, input logic [47:0] s);
        logic [110:0] f;
        f = {c, 8'h3C, b, dst, 3'h0, s, 40'h0};
        return {f, ^f};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Ready is looked at before the edge, where it has settled
    task automatic wait_rdy();
        logic r;
        int n;
        n = 0;
        r = 1'b0;
        while (r !== 1'b1) begin
            @(negedge hclk);
            r = rdy;
            d = hrdata;
            @(posedge hclk);
            n++;
            if (n > 50) begin
                fails++;
                report_and_stop();
            end
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a,
            input logic [31:0] v);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= v;
        wait_rdy();
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(d, e);
    endtask
    task automatic pulse(input int i);
        pins[i] <= 1'b1;
        repeat (3) @(posedge hclk);
        pins[i] <= 1'b0;
        repeat (6) @(posedge hclk);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        pins = 3'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`OFF_PERIOD, 32'h0000_0008);
        rd(32'h0000_0100, 32'h0000_0000);
        xfer(1'b1, `OFF_IDS, 32'h0077_5A3C);
        xfer(1'b1, `OFF_STAGE, 32'h0000_0011);
        xfer(1'b1, `OFF_STAGE + 8, 32'h89AB_CDEF);
        xfer(1'b1, `OFF_STAGE_MSB, 32'h0000_0123);
        rd(`OFF_SNAP_ARM, 32'h0000_0000);
        rd(`OFF_SNAP, 32'h0000_0011);
        xfer(1'b0, `OFF_SNAP + 4, 32'h0);
        chk({31'h0, d < 32'd2000}, 32'h1);
        rd(`OFF_SNAP + 8, 32'h89AB_CDEF);
        rd(`OFF_SNAP + 12, 32'h0000_0123);
        xfer(1'b1, `OFF_TRIG, 32'h0000_000C);
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, `OFF_CTRL, {16'h0, cfg[k]});
            case (k)
                0: rd(`OFF_PERIOD, 32'h0000_0008);
                1: pulse(0);
                2: pulse(1);
                default: xfer(1'b1, `OFF_TIMER, 32'd200);
            endcase
            repeat (12) @(posedge hclk);
            rd(`OFF_FIFO_STAT, 32'h1 | (32'h100 << k));
            rd(`OFF_FIFO + 8, 32'h89AB_CDEF);
            rd(`OFF_FIFO_MSB, 32'h0000_0123);
        end
        // Empty FIFO shows a stale tag
        rd(`OFF_FIFO_STAT, 32'h0000_0100);
        xfer(1'b1, `OFF_STAGE + 8, 32'h0000_0005);
        xfer(1'b1, `OFF_CTRL, 32'h0000_0010);
        pulse(0);
        rd(`OFF_SNAP_ARM, 32'h0);
        rd(`OFF_SNAP + 8, 32'h0000_0005);
        xfer(1'b1, `OFF_MATCH, 32'h0);
        xfer(1'b1, `OFF_MATCH + 4, 32'h0000_0005);
        xfer(1'b1, `OFF_MATCH + 8, 32'h0000_0123);
        xfer(1'b1, `OFF_CTRL, 32'h0000_0400);
        repeat (3) @(posedge hclk);
        chk({31'h0, trig}, 32'h1);
        xfer(1'b1, `OFF_MATCH + 4, 32'h0000_0006);
        repeat (3) @(posedge hclk);
        chk({31'h0, trig}, 32'h0);
        xfer(1'b1, `OFF_CTRL, 32'h0000_0040);
        rem.send(mk(`CMD_SECOND, 1'b0, 8'h77, 48'h42));
        rem.send(mk(`CMD_SECOND, 1'b0, 8'h55, 48'h42));
        rem.send(mk(`CMD_SYNC, 1'b0, 8'h77, 48'h42) ^ 112'h1);
        rem.send(mk(`CMD_SYNC, 1'b1, 8'h55, 48'h42));
        @(posedge hclk);
        rd(`OFF_RX_STAT, 32'h0300_0202);
        rd(`OFF_SNAP_ARM, 32'h0);
        rd(`OFF_SNAP + 8, 32'h0000_0042);
        xfer(1'b1, `OFF_CTRL, 32'h0000_6002);
        n0 = rx_cnt;
        pulse(2);
        for (int i = 0; i < 3000 && rx_cnt < n0 + 112; i++) begin
            @(posedge hclk);
        end
        chk(rx_cnt - n0, 112);
        chk(rx[111:80], {3'h0, 8'h3C, 1'b1, 8'h5A, 12'h0});
        chk(rx[72:41], 32'h0000_0042);
        chk({31'h0, ^rx}, 32'h0);
        report_and_stop();
    end
endmodule // test_time_pwm_codec
